// [hw/uif_pkg.sv]
// Package with register map, field positions, timing and carriers.
// How it works
// - All enabled status flags merge into one registered interrupt request output.
// - Status enables only gate the request; flags still latch for polling.
// - Engine-set flags stay set until software writes zero to them.
// - Writing one to a writable status flag sets it.
// - While suspended, only the bus activity flag can be newly raised.
// - Start-of-frame token sets status bit 6.
// - A sent stall handshake sets status bit 5.
// - Constant idle bus for 3 ms sets status bit 4.
// - Bit 3 stays set while transactions queue; clearing it pops one.
// - Line activity sets status bit 2, even while suspended.
// - Bit 1 follows enabled errors only; software cannot set or clear it.
// - Bus reset sets status bit 0 and zeroes the device address.
// - Activity flag ignores clears while suspended and briefly after wake-up.
// - Engine stays stopped after suspend ends until the PLL reports lock.
// - Activity flag rises once per idle; it rearms only after idle.
// - Error flags, gated by their enables, are ORed into bit 1.
// - Each error flag sets in the cycle its error is seen.
// - Bit stuff violation sets error bit 7.
// - More than 16 idle bit times after EOP sets error bit 4.
// - Non-integral data field bytes set error bit 3.
// - Bad token CRC5 rejects the token and sets error bit 1.
// - CRC16 failure sets error bit 2; PID check failure sets bit 0.
// - An error enable of one passes its flag to bit 1; zero blocks.
package uif_pkg;

	localparam int unsigned ADDR_W = 3;
	localparam int unsigned DATA_W = 8;

	localparam logic [2:0] ADDR_STATUS_FLAGS   = 3'h0;
	localparam logic [2:0] ADDR_STATUS_ENABLES = 3'h1;
	localparam logic [2:0] ADDR_ERROR_FLAGS    = 3'h2;
	localparam logic [2:0] ADDR_ERROR_ENABLES  = 3'h3;
	localparam logic [2:0] ADDR_CONTROL        = 3'h4;
	localparam logic [2:0] ADDR_DEVICE_ADDRESS = 3'h5;
	localparam logic [2:0] ADDR_TRANS_STATUS   = 3'h6;

	localparam int unsigned BIT_FRAME_START  = 6;
	localparam int unsigned BIT_STALL_SENT   = 5;
	localparam int unsigned BIT_IDLE_DETECT  = 4;
	localparam int unsigned BIT_TRANS_DONE   = 3;
	localparam int unsigned BIT_BUS_ACTIVITY = 2;
	localparam int unsigned BIT_ERROR_SUM    = 1;
	localparam int unsigned BIT_BUS_RESET    = 0;

	localparam int unsigned BIT_BIT_STUFF  = 7;
	localparam int unsigned BIT_TURNAROUND = 4;
	localparam int unsigned BIT_DATA_SIZE  = 3;
	localparam int unsigned BIT_DATA_CRC   = 2;
	localparam int unsigned BIT_TOKEN_CRC  = 1;
	localparam int unsigned BIT_PACKET_ID  = 0;

	localparam int unsigned BIT_SUSPEND = 1;

	localparam logic [7:0] STATUS_IMPL_MASK = 8'h7F;
	localparam logic [7:0] ERROR_IMPL_MASK  = 8'h9F;
	localparam logic [7:0] RESET_FLAGS      = 8'h00;
	localparam logic [7:0] RESET_ENABLES    = 8'h00;
	localparam logic [7:0] RESET_CONTROL    = 8'h00;
	localparam logic [6:0] RESET_DEV_ADDR   = 7'h00;

	localparam int unsigned CLK_MHZ          = 25;
	localparam int unsigned IDLE_TIME_US     = 3000;
	localparam int unsigned IDLE_CYCLES      = IDLE_TIME_US * CLK_MHZ;
	localparam int unsigned TURNAROUND_BITS  = 16;
	localparam int unsigned BIT_TIME_CYCLES  = 2;
	localparam int unsigned WAKE_SYNC_CYCLES = 4;
	localparam int unsigned TRANS_DEPTH      = 4;

	typedef struct packed {
		logic       frame_start;
		logic       stall_sent;
		logic       trans_done;
		logic [7:0] trans_status;
		logic       bus_reset;
		logic       end_of_packet;
		logic       response_seen;
		logic       bit_stuff_err;
		logic       data_size_err;
		logic       data_crc_err;
		logic       token_crc_err;
		logic       packet_id_err;
	} uif_engine_type;

endpackage : uif_pkg

// [hw/uif_sync3.sv]
// Three-stage synchroniser that accepts a change once stages two and three agree.
`timescale 1ns/1ps
module uif_sync3 #(
	parameter int unsigned WIDTH = 1
) (
	input  wire logic             i_core_clk,
	input  wire logic             i_reset,
	input  wire logic [WIDTH-1:0] i_async,
	output logic      [WIDTH-1:0] o_sync
);
	logic [WIDTH-1:0] stage1;
	logic [WIDTH-1:0] stage2;
	logic [WIDTH-1:0] stage3;

	always_ff @(posedge i_core_clk or posedge i_reset) begin
		if (i_reset) begin
			stage1 <= '0;
			stage2 <= '0;
			stage3 <= '0;
		end else begin
			stage1 <= i_async;
			stage2 <= stage1;
			stage3 <= stage2;
		end
	end

	// Per-bit acceptance keeps a lone glitch in stage two from passing.
	for (genvar b = 0; b < WIDTH; b++) begin : g_accept
		always_ff @(posedge i_core_clk or posedge i_reset) begin
			if (i_reset) begin
				o_sync[b] <= 1'b0;
			end else if (stage2[b] == stage3[b]) begin
				o_sync[b] <= stage3[b];
			end
		end
	end
endmodule : uif_sync3

// [hw/uif_tick_div.sv]
// Divider that emits a one-cycle enable every DIV clock cycles.
`timescale 1ns/1ps
module uif_tick_div #(
	parameter int unsigned DIV = 2
) (
	input  wire logic i_core_clk,
	input  wire logic i_reset,
	input  wire logic i_run,
	output logic      o_tick
);
	localparam int unsigned CW = (DIV > 1) ? $clog2(DIV) : 1;
	localparam logic [CW-1:0] LAST = CW'(DIV - 1);

	logic [CW-1:0] count;

	always_ff @(posedge i_core_clk or posedge i_reset) begin
		if (i_reset) begin
			count  <= '0;
			o_tick <= 1'b0;
		end else if (!i_run) begin
			count  <= '0;
			o_tick <= 1'b0;
		end else begin
			o_tick <= (count == LAST);
			count  <= (count == LAST) ? '0 : count + CW'(1);
		end
	end
endmodule : uif_tick_div

// [hw/uif_top.sv]
// Two-level interrupt funnel with flag, enable and status registers.
//
// Implementation choices: the address-and-strobe port and the placing of the registers.
`timescale 1ns/1ps
module uif_top #(
	parameter int unsigned IDLE_COUNT  = uif_pkg::IDLE_CYCLES,
	parameter int unsigned BIT_DIV     = uif_pkg::BIT_TIME_CYCLES,
	parameter int unsigned TRANS_DEPTH = uif_pkg::TRANS_DEPTH
) (
	input  wire logic                   i_core_clk,
	input  wire logic                   i_reset,
	input  wire logic [2:0]             i_addr,
	input  wire logic [7:0]             i_wr_data,
	input  wire logic                   i_wr_strobe,
	input  wire logic                   i_rd_strobe,
	output logic      [7:0]             o_rd_data,
	input  wire uif_pkg::uif_engine_type i_engine,
	input  wire logic                   i_dplus,
	input  wire logic                   i_dminus,
	input  wire logic                   i_pll_locked,
	output logic                        o_usb_irq_request,
	output logic                        o_token_reject,
	output logic      [6:0]             o_device_address,
	output logic                        o_engine_run
);
	import uif_pkg::*;

	localparam int unsigned IW = $clog2(IDLE_COUNT + 1);
	localparam logic [IW-1:0] IDLE_LAST = IW'(IDLE_COUNT - 1);
	localparam int unsigned PW = (TRANS_DEPTH > 1) ? $clog2(TRANS_DEPTH) : 1;
	localparam int unsigned QW = $clog2(TRANS_DEPTH + 1);
	localparam logic [QW-1:0] Q_FULL = QW'(TRANS_DEPTH);
	localparam logic [4:0] TURN_LAST = 5'(TURNAROUND_BITS);
	localparam logic [2:0] WAKE_LOAD = 3'(WAKE_SYNC_CYCLES);

	logic [2:0]      sync_in;
	logic [1:0]      lines;
	logic [1:0]      lines_prev;
	logic            pll_ok;
	logic            bit_tick;
	logic [7:0]      usb_status_flags;
	logic [7:0]      usb_status_enables;
	logic [7:0]      usb_error_flags;
	logic [7:0]      usb_error_enables;
	logic [7:0]      usb_control_reg;
	logic [7:0]      transaction_status_reg;
	logic [7:0]      next_status;
	logic [7:0]      next_error;
	logic [7:0]      status_set;
	logic [7:0]      error_set;
	logic [7:0]      plain_next;
	logic            suspend;
	logic            suspend_prev;
	logic            run;
	logic [2:0]      wake_count;
	logic            act_blocked;
	logic            act_armed;
	logic            line_change;
	logic [IW-1:0]   idle_count;
	logic            idle_hit;
	logic            turn_active;
	logic [4:0]      turn_bits;
	logic            turn_timeout;
	logic [7:0]      trans_queue [TRANS_DEPTH];
	logic [PW-1:0]   queue_wp;
	logic [PW-1:0]   queue_rp;
	logic [QW-1:0]   queue_count;
	logic [QW-1:0]   next_count;
	logic            push;
	logic            pop;
	logic            wr_status;
	logic            wr_error;

	uif_sync3 #(
		.WIDTH(3)
	) u_sync (
		.i_core_clk(i_core_clk),
		.i_reset   (i_reset),
		.i_async   ({i_dplus, i_dminus, i_pll_locked}),
		.o_sync    (sync_in)
	);

	assign lines  = sync_in[2:1];
	assign pll_ok = sync_in[0];

	uif_tick_div #(
		.DIV(BIT_DIV)
	) u_bit_tick (
		.i_core_clk(i_core_clk),
		.i_reset   (i_reset),
		.i_run     (run),
		.o_tick    (bit_tick)
	);

	assign suspend   = usb_control_reg[BIT_SUSPEND];
	assign wr_status = i_wr_strobe && (i_addr == ADDR_STATUS_FLAGS);
	assign wr_error  = i_wr_strobe && (i_addr == ADDR_ERROR_FLAGS);

	// The engine only runs with suspend off and a locked PLL.
	assign run = !suspend && pll_ok;

	// Wake-up window during which activity clears are not honoured.
	always_ff @(posedge i_core_clk or posedge i_reset) begin
		if (i_reset) begin
			suspend_prev <= 1'b0;
			wake_count   <= '0;
		end else begin
			suspend_prev <= suspend;
			if (suspend_prev && !suspend) begin
				wake_count <= WAKE_LOAD;
			end else if (wake_count != 3'h0) begin
				wake_count <= wake_count - 3'h1;
			end
		end
	end

	assign act_blocked = suspend || (wake_count != 3'h0);

	// Idle means the lines hold still; counting needs the engine clock.
	assign line_change = (lines != lines_prev);

	always_ff @(posedge i_core_clk or posedge i_reset) begin
		if (i_reset) begin
			lines_prev <= '0;
			idle_count <= '0;
			idle_hit   <= 1'b0;
		end else begin
			lines_prev <= lines;
			idle_hit   <= run && !line_change && (idle_count == IDLE_LAST);
			if (line_change || !run) begin
				idle_count <= '0;
			end else if (idle_count != IW'(IDLE_COUNT)) begin
				idle_count <= idle_count + IW'(1);
			end
		end
	end

	// One activity event per idle period; idle rearms it.
	always_ff @(posedge i_core_clk or posedge i_reset) begin
		if (i_reset) begin
			act_armed <= 1'b0;
		end else if (idle_hit) begin
			act_armed <= 1'b1;
		end else if (line_change) begin
			act_armed <= 1'b0;
		end
	end

	// Turnaround timer counts bit times from end of packet to a response.
	always_ff @(posedge i_core_clk or posedge i_reset) begin
		if (i_reset) begin
			turn_active  <= 1'b0;
			turn_bits    <= '0;
			turn_timeout <= 1'b0;
		end else begin
			turn_timeout <= 1'b0;
			if (!run || i_engine.response_seen) begin
				turn_active <= 1'b0;
			end else if (i_engine.end_of_packet) begin
				turn_active <= 1'b1;
				turn_bits   <= '0;
			end else if (turn_active && bit_tick) begin
				if (turn_bits == TURN_LAST) begin
					turn_timeout <= 1'b1;
					turn_active  <= 1'b0;
				end else begin
					turn_bits <= turn_bits + 5'h1;
				end
			end
		end
	end

	// Transaction status queue; the flag stays set while the queue is non-empty.
	assign push = run && i_engine.trans_done && (queue_count != Q_FULL);
	assign pop  = wr_status && !i_wr_data[BIT_TRANS_DONE] &&
	              (queue_count != '0);
	assign next_count = queue_count + QW'(push) - QW'(pop);

	always_ff @(posedge i_core_clk or posedge i_reset) begin
		if (i_reset) begin
			queue_wp    <= '0;
			queue_rp    <= '0;
			queue_count <= '0;
		end else begin
			queue_count <= next_count;
			if (push) begin
				queue_wp <= (queue_wp == PW'(TRANS_DEPTH - 1)) ?
				            '0 : queue_wp + PW'(1);
			end
			if (pop) begin
				queue_rp <= (queue_rp == PW'(TRANS_DEPTH - 1)) ?
				            '0 : queue_rp + PW'(1);
			end
		end
	end

	always_ff @(posedge i_core_clk) begin
		if (push) begin
			trans_queue[queue_wp] <= i_engine.trans_status;
		end
	end

	assign transaction_status_reg = (queue_count != '0) ?
	                                trans_queue[queue_rp] : 8'h00;

	// Hardware set sources; all but activity need a running engine.
	always_comb begin
		status_set = 8'h00;
		status_set[BIT_FRAME_START]  = run && i_engine.frame_start;
		status_set[BIT_STALL_SENT]   = run && i_engine.stall_sent;
		status_set[BIT_IDLE_DETECT]  = idle_hit;
		status_set[BIT_BUS_ACTIVITY] = act_armed && line_change;
		status_set[BIT_BUS_RESET]    = run && i_engine.bus_reset;
		error_set = 8'h00;
		error_set[BIT_BIT_STUFF]  = run && i_engine.bit_stuff_err;
		error_set[BIT_TURNAROUND] = turn_timeout;
		error_set[BIT_DATA_SIZE]  = run && i_engine.data_size_err;
		error_set[BIT_DATA_CRC]   = run && i_engine.data_crc_err;
		error_set[BIT_TOKEN_CRC]  = run && i_engine.token_crc_err;
		error_set[BIT_PACKET_ID]  = run && i_engine.packet_id_err;
	end

	// Per bit: a hardware set wins over a software write of zero.
	for (genvar b = 0; b < 8; b++) begin : g_bits
		assign plain_next[b] = status_set[b] |
		       (wr_status ? i_wr_data[b] : usb_status_flags[b]);
		assign next_error[b] = ERROR_IMPL_MASK[b] & (error_set[b] |
		       (usb_error_flags[b] & ~(wr_error & ~i_wr_data[b])));
	end

	always_comb begin
		next_status = plain_next & STATUS_IMPL_MASK;
		next_status[BIT_TRANS_DONE] = (next_count != '0) ||
		       (wr_status ? i_wr_data[BIT_TRANS_DONE] :
		        usb_status_flags[BIT_TRANS_DONE] && (queue_count == '0));
		if (act_blocked && usb_status_flags[BIT_BUS_ACTIVITY]) begin
			next_status[BIT_BUS_ACTIVITY] = 1'b1;
		end
		next_status[BIT_ERROR_SUM] =
		       |(next_error & usb_error_enables);
	end

	always_ff @(posedge i_core_clk or posedge i_reset) begin
		if (i_reset) begin
			usb_status_flags <= RESET_FLAGS;
			usb_error_flags  <= RESET_FLAGS;
		end else begin
			usb_status_flags <= next_status;
			usb_error_flags  <= next_error;
		end
	end

	always_ff @(posedge i_core_clk or posedge i_reset) begin
		if (i_reset) begin
			usb_status_enables <= RESET_ENABLES;
			usb_error_enables  <= RESET_ENABLES;
			usb_control_reg    <= RESET_CONTROL;
		end else if (i_wr_strobe) begin
			if (i_addr == ADDR_STATUS_ENABLES) begin
				usb_status_enables <= i_wr_data & STATUS_IMPL_MASK;
			end
			if (i_addr == ADDR_ERROR_ENABLES) begin
				usb_error_enables <= i_wr_data & ERROR_IMPL_MASK;
			end
			if (i_addr == ADDR_CONTROL) begin
				usb_control_reg <= i_wr_data & 8'h02;
			end
		end
	end

	// Bus reset overrides a same-cycle software write of the address.
	always_ff @(posedge i_core_clk or posedge i_reset) begin
		if (i_reset) begin
			o_device_address <= RESET_DEV_ADDR;
		end else if (run && i_engine.bus_reset) begin
			o_device_address <= RESET_DEV_ADDR;
		end else if (i_wr_strobe && (i_addr == ADDR_DEVICE_ADDRESS)) begin
			o_device_address <= i_wr_data[6:0];
		end
	end

	always_ff @(posedge i_core_clk or posedge i_reset) begin
		if (i_reset) begin
			o_usb_irq_request <= 1'b0;
			o_token_reject    <= 1'b0;
			o_engine_run      <= 1'b0;
		end else begin
			o_usb_irq_request <=
			       |(usb_status_flags & usb_status_enables);
			o_token_reject <= run && i_engine.token_crc_err;
			o_engine_run   <= run;
		end
	end

	// Unmapped addresses read as zero.
	always_ff @(posedge i_core_clk or posedge i_reset) begin
		if (i_reset) begin
			o_rd_data <= 8'h00;
		end else if (i_rd_strobe) begin
			unique case (i_addr)
				ADDR_STATUS_FLAGS:   o_rd_data <= usb_status_flags;
				ADDR_STATUS_ENABLES: o_rd_data <= usb_status_enables;
				ADDR_ERROR_FLAGS:    o_rd_data <= usb_error_flags;
				ADDR_ERROR_ENABLES:  o_rd_data <= usb_error_enables;
				ADDR_CONTROL:        o_rd_data <= usb_control_reg;
				ADDR_DEVICE_ADDRESS: o_rd_data <= {1'b0, o_device_address};
				ADDR_TRANS_STATUS:   o_rd_data <= transaction_status_reg;
				default:             o_rd_data <= 8'h00;
			endcase
		end else begin
			o_rd_data <= 8'h00;
		end
	end

	// Armed means an idle period was flagged and no activity has followed.
	sequence s_idle_seen;
		act_armed;
	endsequence

	sequence s_activity_after;
		line_change;
	endsequence

	AST_IRQ_FUNNEL: assert property (@(posedge i_core_clk) disable iff (i_reset)
		(|(usb_status_flags & usb_status_enables)) |=> o_usb_irq_request)
		else $error("Enabled status flag did not raise the request.");

	AST_POLL_MASKED: assert property (@(posedge i_core_clk) disable iff (i_reset)
		(run && i_engine.frame_start && !usb_status_enables[BIT_FRAME_START])
		|=> usb_status_flags[BIT_FRAME_START])
		else $error("Masked frame start was not latched.");

	AST_HOLD_UNTIL_CLEAR: assert property (@(posedge i_core_clk) disable iff (i_reset)
		(usb_error_flags[BIT_DATA_CRC] && !wr_error) |=> usb_error_flags[BIT_DATA_CRC])
		else $error("Error flag dropped without a clear.");

	AST_SOFTWARE_SET: assert property (@(posedge i_core_clk) disable iff (i_reset)
		(wr_status && i_wr_data[BIT_STALL_SENT]) |=> usb_status_flags[BIT_STALL_SENT])
		else $error("Software set of stall flag failed.");

	AST_SUSPEND_QUIET: assert property (@(posedge i_core_clk) disable iff (i_reset)
		(suspend && !usb_status_flags[BIT_FRAME_START] && !wr_status)
		|=> !usb_status_flags[BIT_FRAME_START])
		else $error("Frame start flag raised while suspended.");

	AST_RESET_ADDRESS: assert property (@(posedge i_core_clk) disable iff (i_reset)
		(run && i_engine.bus_reset)
		|=> (o_device_address == 7'h00) && usb_status_flags[BIT_BUS_RESET])
		else $error("Bus reset did not clear the address.");

	AST_ACT_NO_CLEAR: assert property (@(posedge i_core_clk) disable iff (i_reset)
		(act_blocked && usb_status_flags[BIT_BUS_ACTIVITY] && wr_status)
		|=> usb_status_flags[BIT_BUS_ACTIVITY])
		else $error("Activity flag cleared while blocked.");

	AST_ACT_ONCE: assert property (@(posedge i_core_clk) disable iff (i_reset)
		(line_change && !act_armed && !usb_status_flags[BIT_BUS_ACTIVITY] && !wr_status)
		|=> !usb_status_flags[BIT_BUS_ACTIVITY])
		else $error("Activity flag rose without a prior idle.");

	AST_IDLE_THEN_ACT: assert property (@(posedge i_core_clk) disable iff (i_reset)
		s_idle_seen ##0 s_activity_after |=> usb_status_flags[BIT_BUS_ACTIVITY])
		else $error("Activity after idle was not flagged.");

	AST_ERROR_SUMMARY: assert property (@(posedge i_core_clk) disable iff (i_reset)
		$stable(usb_error_enables) |->
		    usb_status_flags[BIT_ERROR_SUM] ==
		    (|(usb_error_flags & usb_error_enables)))
		else $error("Error summary does not follow enabled errors.");

	AST_ERROR_IMMEDIATE: assert property (@(posedge i_core_clk) disable iff (i_reset)
		(run && i_engine.bit_stuff_err) |=> usb_error_flags[BIT_BIT_STUFF])
		else $error("Bit stuff error flag was late.");

	AST_TOKEN_REJECT: assert property (@(posedge i_core_clk) disable iff (i_reset)
		(run && i_engine.token_crc_err)
		|=> o_token_reject && usb_error_flags[BIT_TOKEN_CRC])
		else $error("Bad token CRC was not rejected.");

	AST_TRANS_PENDING: assert property (@(posedge i_core_clk) disable iff (i_reset)
		(queue_count != '0) |-> usb_status_flags[BIT_TRANS_DONE] || $rose(queue_count != '0))
		else $error("Pending transaction without its flag.");
endmodule : uif_top

// [sim/uif_host_model.sv]
// Far-side model: engine event pulses, bus lines, PLL lock and the CPU latch.
`timescale 1ns/1ps
module uif_host_model (
	input  wire logic               i_core_clk,
	input  wire logic               i_irq,
	output uif_pkg::uif_engine_type o_engine,
	output logic                    o_dplus,
	output logic                    o_dminus,
	output logic                    o_pll_locked,
	output logic                    o_irq_seen
);
	import uif_pkg::*;
	initial begin
		o_engine     = '0;
		o_dplus      = 1'b1;
		o_dminus     = 1'b0;
		o_pll_locked = 1'b1;
		o_irq_seen   = 1'b0;
	end
	// The processor side only latches the request; nothing here clears it.
	always @(posedge i_core_clk) begin
		if (i_irq === 1'b1) begin
			o_irq_seen <= 1'b1;
		end
	end
	task automatic send(input logic [18:0] ev);
		@(posedge i_core_clk);
		o_engine <= uif_engine_type'(ev);
		@(posedge i_core_clk);
		o_engine <= '0;
	endtask : send
	// Only the change of line state counts as activity, so a flip suffices.
	task automatic wiggle();
		@(posedge i_core_clk);
		o_dplus  <= ~o_dplus;
		o_dminus <= ~o_dminus;
	endtask : wiggle
	task automatic lock(input logic l);
		@(posedge i_core_clk);
		o_pll_locked <= l;
	endtask : lock
endmodule : uif_host_model

// [sim/uif_top_tb_top.sv]
// Self-checking testbench for the interrupt funnel.
`timescale 1ns/1ps
module uif_top_tb_top;
	import uif_pkg::*;
	logic           i_core_clk;
	logic           i_reset;
	logic           i_wr_strobe;
	logic           i_rd_strobe;
	logic [2:0]     i_addr;
	logic [7:0]     i_wr_data;
	logic [7:0]     o_rd_data;
	logic [7:0]     v;
	logic           o_usb_irq_request;
	logic           o_token_reject;
	logic           o_engine_run;
	logic           irq_seen;
	logic [6:0]     o_device_address;
	logic           dplus;
	logic           dminus;
	logic           pll_locked;
	uif_engine_type engine;
	int             n_fail = 0;
	int             comparisons = 0;

	uif_top #(.IDLE_COUNT(1000)) dut (
		.i_core_clk(i_core_clk), .i_reset(i_reset), .i_addr(i_addr),
		.i_wr_data(i_wr_data), .i_wr_strobe(i_wr_strobe),
		.i_rd_strobe(i_rd_strobe), .o_rd_data(o_rd_data),
		.i_engine(engine), .i_dplus(dplus), .i_dminus(dminus),
		.i_pll_locked(pll_locked), .o_usb_irq_request(o_usb_irq_request),
		.o_token_reject(o_token_reject),
		.o_device_address(o_device_address), .o_engine_run(o_engine_run));
	uif_host_model host (
		.i_core_clk(i_core_clk), .i_irq(o_usb_irq_request), .o_engine(engine),
		.o_dplus(dplus), .o_dminus(dminus), .o_pll_locked(pll_locked),
		.o_irq_seen(irq_seen));

	task automatic tally_and_finish();
		$display("comparisons=%0d n_fail=%0d", comparisons, n_fail);
		if (n_fail == 0 && comparisons > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask : tally_and_finish
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		comparisons++;
		if (got !== exp) begin
			n_fail++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	task automatic wr(input logic [2:0] a, input logic [7:0] d);
		@(posedge i_core_clk);
		i_addr      <= a;
		i_wr_data   <= d;
		i_wr_strobe <= 1'b1;
		@(posedge i_core_clk);
		i_wr_strobe <= 1'b0;
	endtask : wr
	task automatic rd(input logic [2:0] a, output logic [7:0] d);
		@(posedge i_core_clk);
		i_addr      <= a;
		i_rd_strobe <= 1'b1;
		@(posedge i_core_clk);
		i_rd_strobe <= 1'b0;
		#1 d = o_rd_data;
	endtask : rd
	task automatic rdchk(input logic [2:0] a, input logic [7:0] exp,
		input logic [7:0] m = 8'hFF);
		logic [7:0] d;
		rd(a, d);
		chk(d & m, exp);
	endtask : rdchk

	initial begin
		i_core_clk = 1'b0;
		forever #20 i_core_clk = ~i_core_clk;
	end
	// A hang anywhere ends the run through the same closing report.
	initial begin
		repeat (20000) @(posedge i_core_clk);
		n_fail++;
		tally_and_finish();
	end

	initial begin
		i_reset = 1'b1; i_addr = '0; i_wr_data = '0;
		i_wr_strobe = 1'b0; i_rd_strobe = 1'b0;
		repeat (16) @(posedge i_core_clk);
		i_reset <= 1'b0;
		for (int a = 0; a < 8; a++) rdchk(a[2:0], 8'h00);
		$display("reset values done");
		wr(ADDR_DEVICE_ADDRESS, 8'h2A);
		rdchk(ADDR_DEVICE_ADDRESS, 8'h2A);
		host.send(19'h40000);
		host.send(19'h20000);
		host.send(19'h00080);
		rdchk(ADDR_STATUS_FLAGS, 8'h61);
		rdchk(ADDR_DEVICE_ADDRESS, 8'h00);
		chk({1'b0, o_device_address}, 8'h00);
		chk({7'h0, o_usb_irq_request}, 8'h00);
		wr(ADDR_STATUS_ENABLES, 8'h40);
		repeat (3) @(posedge i_core_clk);
		chk({7'h0, o_usb_irq_request}, 8'h01);
		chk({7'h0, irq_seen}, 8'h01);
		rdchk(ADDR_STATUS_ENABLES, 8'h40);
		wr(ADDR_STATUS_FLAGS, 8'h00);
		rdchk(ADDR_STATUS_FLAGS, 8'h00);
		chk({7'h0, o_usb_irq_request}, 8'h00);
		wr(ADDR_STATUS_FLAGS, 8'hFF);
		rdchk(ADDR_STATUS_FLAGS, 8'h7D);
		wr(ADDR_STATUS_FLAGS, 8'h00);
		wr(ADDR_STATUS_ENABLES, 8'h00);
		$display("status flags done");
		host.send(19'h1A500);
		host.send(19'h15A00);
		rdchk(ADDR_STATUS_FLAGS, 8'h08);
		rdchk(ADDR_TRANS_STATUS, 8'hA5);
		wr(ADDR_STATUS_FLAGS, 8'h00);
		rdchk(ADDR_STATUS_FLAGS, 8'h08);
		rdchk(ADDR_TRANS_STATUS, 8'h5A);
		wr(ADDR_STATUS_FLAGS, 8'h00);
		rdchk(ADDR_STATUS_FLAGS, 8'h00);
		$display("transaction queue done");
		v = 8'h00;
		for (int i = 0; i < 5; i++) begin
			host.send(19'h1 << i);
			#1 chk({7'h0, o_token_reject}, {7'h0, i == 1});
			v = v | ((i == 4) ? 8'h80 : (8'h01 << i));
			rdchk(ADDR_ERROR_FLAGS, v);
		end
		rdchk(ADDR_STATUS_FLAGS, 8'h00);
		wr(ADDR_ERROR_FLAGS, 8'hFF);
		rdchk(ADDR_ERROR_FLAGS, 8'h8F);
		wr(ADDR_ERROR_FLAGS, 8'h00);
		wr(ADDR_ERROR_ENABLES, 8'h04);
		host.send(19'h00010);
		rdchk(ADDR_STATUS_FLAGS, 8'h00);
		host.send(19'h00004);
		wr(ADDR_STATUS_FLAGS, 8'h00);
		rdchk(ADDR_STATUS_FLAGS, 8'h02);
		wr(ADDR_ERROR_ENABLES, 8'h00);
		wr(ADDR_ERROR_FLAGS, 8'h00);
		host.send(19'h00040);
		repeat (10) @(posedge i_core_clk);
		host.send(19'h00020);
		repeat (40) @(posedge i_core_clk);
		rdchk(ADDR_ERROR_FLAGS, 8'h00);
		host.send(19'h00040);
		repeat (26) @(posedge i_core_clk);
		rdchk(ADDR_ERROR_FLAGS, 8'h00);
		repeat (10) @(posedge i_core_clk);
		rdchk(ADDR_ERROR_FLAGS, 8'h10);
		wr(ADDR_ERROR_FLAGS, 8'h00);
		$display("error flags done");
		wr(ADDR_CONTROL, 8'h02);
		rdchk(ADDR_CONTROL, 8'h02);
		chk({7'h0, o_engine_run}, 8'h00);
		host.send(19'h40000);
		rdchk(ADDR_STATUS_FLAGS, 8'h00, 8'hFD);
		host.lock(1'b0);
		repeat (8) @(posedge i_core_clk);
		wr(ADDR_CONTROL, 8'h00);
		repeat (8) @(posedge i_core_clk);
		chk({7'h0, o_engine_run}, 8'h00);
		host.send(19'h40000);
		rdchk(ADDR_STATUS_FLAGS, 8'h00, 8'hFD);
		host.lock(1'b1);
		repeat (8) @(posedge i_core_clk);
		chk({7'h0, o_engine_run}, 8'h01);
		$display("suspend done");
		v = 8'h00;
		for (int k = 0; k < 1200 && v[4] !== 1'b1; k++) rd(ADDR_STATUS_FLAGS, v);
		if (v[4] !== 1'b1) begin
			n_fail++;
			tally_and_finish();
		end
		chk(v & 8'hFD, 8'h10);
		wr(ADDR_CONTROL, 8'h02);
		host.wiggle();
		repeat (10) @(posedge i_core_clk);
		rdchk(ADDR_STATUS_FLAGS, 8'h14, 8'hFD);
		wr(ADDR_STATUS_FLAGS, 8'h10);
		rdchk(ADDR_STATUS_FLAGS, 8'h14, 8'hFD);
		wr(ADDR_CONTROL, 8'h00);
		v = 8'hFF;
		for (int k = 0; k < 12 && v[2] !== 1'b0; k++) begin
			rd(ADDR_STATUS_FLAGS, v);
			if (v[2] !== 1'b0) wr(ADDR_STATUS_FLAGS, 8'h10);
		end
		rdchk(ADDR_STATUS_FLAGS, 8'h10, 8'hFD);
		host.wiggle();
		repeat (10) @(posedge i_core_clk);
		rdchk(ADDR_STATUS_FLAGS, 8'h10, 8'hFD);
		$display("idle and activity done");
		wr(ADDR_DEVICE_ADDRESS, 8'h15);
		@(posedge i_core_clk);
		i_reset <= 1'b1;
		repeat (2) @(posedge i_core_clk);
		i_reset <= 1'b0;
		rdchk(ADDR_STATUS_FLAGS, 8'h00);
		rdchk(ADDR_DEVICE_ADDRESS, 8'h00);
		$display("mid-run reset done");
		tally_and_finish();
	end
endmodule : uif_top_tb_top
